// ---- core/pin_function_select.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - first pin field is bits 4..0; code zero drives serial output 0.
// - first pin field resets to volume-up code, acting as volume-up button.
// - first pin with PDM code drives the modulator output; other pins lack it.
// - second pin field resets to zero; zero carries bit clock, others control.
// - third pin field resets to zero; zero carries frame clock, others control.
// - fourth pin field resets to zero; zero is digital mic 0/1 input.
// - any pin with bypass code requests DSP core bypass by its level.
// - any pin with up or down code acts as volume up or down button.
module pin_function_select (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SERIAL_OUT0_PDM_PIN_IN,
    output logic SERIAL_OUT0_PDM_PIN_OUT,
    output logic SERIAL_OUT0_PDM_PIN_OE,
    input wire logic BIT_CLOCK_PIN_IN,
    output logic BIT_CLOCK_PIN_OUT,
    output logic BIT_CLOCK_PIN_OE,
    input wire logic FRAME_CLOCK_PIN_IN,
    output logic FRAME_CLOCK_PIN_OUT,
    output logic FRAME_CLOCK_PIN_OE,
    input wire logic DIGITAL_MIC01_PIN_IN,
    output logic DIGITAL_MIC01_PIN_OUT,
    output logic DIGITAL_MIC01_PIN_OE,
    input wire logic SERIAL_OUT0_DATA,
    input wire logic PULSE_DENSITY_OUT,
    input wire logic BIT_CLOCK_DRIVE,
    input wire logic BIT_CLOCK_SOURCE,
    input wire logic FRAME_CLOCK_DRIVE,
    input wire logic FRAME_CLOCK_SOURCE,
    output logic BIT_CLOCK_SEEN,
    output logic FRAME_CLOCK_SEEN,
    output logic MIC01_DATA,
    output logic [3:0] MUTE_ADC,
    output logic [1:0] MUTE_DAC,
    output logic BANK_SWITCH,
    output logic COMPRESS_EN,
    output logic DSP_BYPASS,
    output logic VOL_UP,
    output logic VOL_DOWN
);

    // map a role code and pin level onto the control action vector
    function automatic logic [pin_function_pkg::ACT_WIDTH-1:0] role_action(
        input logic [4:0] code,
        input logic level
    );
        logic [pin_function_pkg::ACT_WIDTH-1:0] act;
        act = '0;
        case (code)
            pin_function_pkg::CODE_MUTE_ADC0: act[pin_function_pkg::ACT_ADC_LSB + 0] = level;
            pin_function_pkg::CODE_MUTE_ADC1: act[pin_function_pkg::ACT_ADC_LSB + 1] = level;
            pin_function_pkg::CODE_MUTE_ADC2: act[pin_function_pkg::ACT_ADC_LSB + 2] = level;
            pin_function_pkg::CODE_MUTE_ADC3: act[pin_function_pkg::ACT_ADC_LSB + 3] = level;
            pin_function_pkg::CODE_MUTE_ADC01: act[pin_function_pkg::ACT_ADC_LSB +: 2] = {2{level}};
            pin_function_pkg::CODE_MUTE_ADC23: act[pin_function_pkg::ACT_ADC_LSB + 2 +: 2] = {2{level}};
            pin_function_pkg::CODE_MUTE_ADC_ALL: act[pin_function_pkg::ACT_ADC_LSB +: 4] = {4{level}};
            pin_function_pkg::CODE_MUTE_DAC0: act[pin_function_pkg::ACT_DAC_LSB + 0] = level;
            pin_function_pkg::CODE_MUTE_DAC1: act[pin_function_pkg::ACT_DAC_LSB + 1] = level;
            pin_function_pkg::CODE_MUTE_DAC_ALL: act[pin_function_pkg::ACT_DAC_LSB +: 2] = {2{level}};
            pin_function_pkg::CODE_BANK_SWITCH: act[pin_function_pkg::ACT_BANK] = level;
            pin_function_pkg::CODE_COMPRESS: act[pin_function_pkg::ACT_COMPRESS] = level;
            pin_function_pkg::CODE_BYPASS: act[pin_function_pkg::ACT_BYPASS] = level;
            pin_function_pkg::CODE_VOL_UP: act[pin_function_pkg::ACT_VOL_UP] = level;
            pin_function_pkg::CODE_VOL_DOWN: act[pin_function_pkg::ACT_VOL_DOWN] = level;
            default: act = '0;
        endcase
        return act;
    endfunction : role_action

    // selection registers and bus data-phase state
    logic [7:0] pin1_function_select;
    logic [7:0] pin2_function_select;
    logic [7:0] pin3_function_select;
    logic [7:0] pin4_function_select;
    logic [7:0] next_pin1_function_select;
    logic [7:0] next_pin2_function_select;
    logic [7:0] next_pin3_function_select;
    logic [7:0] next_pin4_function_select;
    logic wr_pending;
    logic next_wr_pending;
    logic [7:0] wr_index;
    logic [7:0] next_wr_index;
    logic [31:0] next_hrdata;
    logic addr_phase;
    logic addr_in_range;
    logic [7:0] addr_index;
    logic [3:0] pin_levels;

    // role codes, reserved upper bits dropped
    logic [4:0] pin1_role_code;
    logic [4:0] pin2_role_code;
    logic [4:0] pin3_role_code;
    logic [4:0] pin4_role_code;
    assign pin1_role_code = pin1_function_select[pin_function_pkg::ROLE_MSB:pin_function_pkg::ROLE_LSB];
    assign pin2_role_code = pin2_function_select[pin_function_pkg::ROLE_MSB:pin_function_pkg::ROLE_LSB];
    assign pin3_role_code = pin3_function_select[pin_function_pkg::ROLE_MSB:pin_function_pkg::ROLE_LSB];
    assign pin4_role_code = pin4_function_select[pin_function_pkg::ROLE_MSB:pin_function_pkg::ROLE_LSB];

    // address phase qualification and decode
    assign addr_phase = HSEL && HREADY && (HTRANS == pin_function_pkg::HTRANS_NONSEQ);
    assign addr_in_range = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
    assign addr_index = HADDR[9:2];
    assign pin_levels = {DIGITAL_MIC01_PIN_IN, FRAME_CLOCK_PIN_IN, BIT_CLOCK_PIN_IN, SERIAL_OUT0_PDM_PIN_IN};

    // register writes in data phase, read data prepared in address phase
    always_comb begin
        logic [7:0] cur1;
        logic [7:0] cur2;
        logic [7:0] cur3;
        logic [7:0] cur4;
        cur1 = pin1_function_select;
        cur2 = pin2_function_select;
        cur3 = pin3_function_select;
        cur4 = pin4_function_select;
        if (wr_pending) begin
            case (wr_index)
                pin_function_pkg::IDX_PIN1_SELECT: cur1 = HWDATA[7:0];
                pin_function_pkg::IDX_PIN2_SELECT: cur2 = HWDATA[7:0];
                pin_function_pkg::IDX_PIN3_SELECT: cur3 = HWDATA[7:0];
                pin_function_pkg::IDX_PIN4_SELECT: cur4 = HWDATA[7:0];
                default: cur1 = pin1_function_select;
            endcase
        end
        next_pin1_function_select = cur1;
        next_pin2_function_select = cur2;
        next_pin3_function_select = cur3;
        next_pin4_function_select = cur4;
        next_wr_pending = addr_phase && HWRITE && addr_in_range;
        next_wr_index = addr_phase ? addr_index : wr_index;
        next_hrdata = HRDATA;
        if (addr_phase && !HWRITE) begin
            next_hrdata = 32'h00000000;
            if (addr_in_range) begin
                case (addr_index)
                    pin_function_pkg::IDX_PIN1_SELECT: next_hrdata = {24'h000000, cur1};
                    pin_function_pkg::IDX_PIN2_SELECT: next_hrdata = {24'h000000, cur2};
                    pin_function_pkg::IDX_PIN3_SELECT: next_hrdata = {24'h000000, cur3};
                    pin_function_pkg::IDX_PIN4_SELECT: next_hrdata = {24'h000000, cur4};
                    pin_function_pkg::IDX_PIN_LEVEL: next_hrdata = {28'h0000000, pin_levels};
                    default: next_hrdata = 32'h00000000;
                endcase
            end
        end
    end

    // register stage for bus and configuration
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pin1_function_select <= pin_function_pkg::RST_PIN1_SELECT;
            pin2_function_select <= pin_function_pkg::RST_PIN2_SELECT;
            pin3_function_select <= pin_function_pkg::RST_PIN3_SELECT;
            pin4_function_select <= pin_function_pkg::RST_PIN4_SELECT;
            wr_pending <= 1'b0;
            wr_index <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= pin_function_pkg::HRESP_OKAY;
        end else if (CE) begin
            pin1_function_select <= next_pin1_function_select;
            pin2_function_select <= next_pin2_function_select;
            pin3_function_select <= next_pin3_function_select;
            pin4_function_select <= next_pin4_function_select;
            wr_pending <= next_wr_pending;
            wr_index <= next_wr_index;
            HRDATA <= next_hrdata;
            HREADYOUT <= 1'b1; // zero wait states
            HRESP <= pin_function_pkg::HRESP_OKAY;
        end
    end

    // pin drive, primary-role inputs and merged control actions
    logic next_pin1_out;
    logic next_pin1_oe;
    logic next_pin2_out;
    logic next_pin2_oe;
    logic next_pin3_out;
    logic next_pin3_oe;
    logic next_bit_clock_seen;
    logic next_frame_clock_seen;
    logic next_mic01_data;
    logic [pin_function_pkg::ACT_WIDTH-1:0] next_action;
    logic [pin_function_pkg::ACT_WIDTH-1:0] action;

    always_comb begin
        next_pin1_out = 1'b0;
        next_pin1_oe = 1'b0;
        if (pin1_role_code == pin_function_pkg::CODE_PRIMARY) begin
            next_pin1_out = SERIAL_OUT0_DATA;
            next_pin1_oe = 1'b1;
        end else if (pin1_role_code == pin_function_pkg::CODE_PDM_OUT) begin
            next_pin1_out = PULSE_DENSITY_OUT;
            next_pin1_oe = 1'b1;
        end
        next_pin2_oe = (pin2_role_code == pin_function_pkg::CODE_PRIMARY) && BIT_CLOCK_DRIVE;
        next_pin2_out = next_pin2_oe ? BIT_CLOCK_SOURCE : 1'b0;
        next_pin3_oe = (pin3_role_code == pin_function_pkg::CODE_PRIMARY) && FRAME_CLOCK_DRIVE;
        next_pin3_out = next_pin3_oe ? FRAME_CLOCK_SOURCE : 1'b0;
        next_bit_clock_seen = (pin2_role_code == pin_function_pkg::CODE_PRIMARY) ? BIT_CLOCK_PIN_IN : 1'b0;
        next_frame_clock_seen = (pin3_role_code == pin_function_pkg::CODE_PRIMARY) ? FRAME_CLOCK_PIN_IN : 1'b0;
        next_mic01_data = (pin4_role_code == pin_function_pkg::CODE_PRIMARY) ? DIGITAL_MIC01_PIN_IN : 1'b0;
        // the pdm code is not a control code, so pin 1 yields nothing then
        next_action = role_action(pin1_role_code, SERIAL_OUT0_PDM_PIN_IN)
                    | role_action(pin2_role_code, BIT_CLOCK_PIN_IN)
                    | role_action(pin3_role_code, FRAME_CLOCK_PIN_IN)
                    | role_action(pin4_role_code, DIGITAL_MIC01_PIN_IN);
    end

    // register stage for pin outputs and controls
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            SERIAL_OUT0_PDM_PIN_OUT <= 1'b0;
            SERIAL_OUT0_PDM_PIN_OE <= 1'b0;
            BIT_CLOCK_PIN_OUT <= 1'b0;
            BIT_CLOCK_PIN_OE <= 1'b0;
            FRAME_CLOCK_PIN_OUT <= 1'b0;
            FRAME_CLOCK_PIN_OE <= 1'b0;
            DIGITAL_MIC01_PIN_OUT <= 1'b0;
            DIGITAL_MIC01_PIN_OE <= 1'b0;
            BIT_CLOCK_SEEN <= 1'b0;
            FRAME_CLOCK_SEEN <= 1'b0;
            MIC01_DATA <= 1'b0;
            action <= '0;
        end else if (CE) begin
            SERIAL_OUT0_PDM_PIN_OUT <= next_pin1_out;
            SERIAL_OUT0_PDM_PIN_OE <= next_pin1_oe;
            BIT_CLOCK_PIN_OUT <= next_pin2_out;
            BIT_CLOCK_PIN_OE <= next_pin2_oe;
            FRAME_CLOCK_PIN_OUT <= next_pin3_out;
            FRAME_CLOCK_PIN_OE <= next_pin3_oe;
            DIGITAL_MIC01_PIN_OUT <= 1'b0; // microphone pin is input only
            DIGITAL_MIC01_PIN_OE <= 1'b0;
            BIT_CLOCK_SEEN <= next_bit_clock_seen;
            FRAME_CLOCK_SEEN <= next_frame_clock_seen;
            MIC01_DATA <= next_mic01_data;
            action <= next_action;
        end
    end

    // control outputs straight from the action register
    assign MUTE_ADC = action[pin_function_pkg::ACT_ADC_LSB +: 4];
    assign MUTE_DAC = action[pin_function_pkg::ACT_DAC_LSB +: 2];
    assign BANK_SWITCH = action[pin_function_pkg::ACT_BANK];
    assign COMPRESS_EN = action[pin_function_pkg::ACT_COMPRESS];
    assign DSP_BYPASS = action[pin_function_pkg::ACT_BYPASS];
    assign VOL_UP = action[pin_function_pkg::ACT_VOL_UP];
    assign VOL_DOWN = action[pin_function_pkg::ACT_VOL_DOWN];

endmodule : pin_function_select

`default_nettype wire

// ---- include/pin_function_pkg.sv ----
package pin_function_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN1_SELECT = 8'h39;
    localparam logic [7:0] IDX_PIN2_SELECT = 8'h3A;
    localparam logic [7:0] IDX_PIN3_SELECT = 8'h3B;
    localparam logic [7:0] IDX_PIN4_SELECT = 8'h3C;
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h40;
    // reset values
    localparam logic [7:0] RST_PIN1_SELECT = 8'h10;
    localparam logic [7:0] RST_PIN2_SELECT = 8'h00;
    localparam logic [7:0] RST_PIN3_SELECT = 8'h00;
    localparam logic [7:0] RST_PIN4_SELECT = 8'h00;
    // function field position
    localparam int ROLE_LSB = 0;
    localparam int ROLE_MSB = 4;
    // role codes
    localparam logic [4:0] CODE_PRIMARY = 5'h00;
    localparam logic [4:0] CODE_MUTE_ADC0 = 5'h01;
    localparam logic [4:0] CODE_MUTE_ADC1 = 5'h02;
    localparam logic [4:0] CODE_MUTE_ADC2 = 5'h03;
    localparam logic [4:0] CODE_MUTE_ADC3 = 5'h04;
    localparam logic [4:0] CODE_MUTE_ADC01 = 5'h05;
    localparam logic [4:0] CODE_MUTE_ADC23 = 5'h06;
    localparam logic [4:0] CODE_MUTE_ADC_ALL = 5'h07;
    localparam logic [4:0] CODE_MUTE_DAC0 = 5'h08;
    localparam logic [4:0] CODE_MUTE_DAC1 = 5'h09;
    localparam logic [4:0] CODE_MUTE_DAC_ALL = 5'h0A;
    localparam logic [4:0] CODE_BANK_SWITCH = 5'h0B;
    localparam logic [4:0] CODE_COMPRESS = 5'h0E;
    localparam logic [4:0] CODE_BYPASS = 5'h0F;
    localparam logic [4:0] CODE_VOL_UP = 5'h10;
    localparam logic [4:0] CODE_VOL_DOWN = 5'h11;
    localparam logic [4:0] CODE_PDM_OUT = 5'h12;
    // action vector layout
    localparam int ACT_WIDTH = 11;
    localparam int ACT_ADC_LSB = 0;
    localparam int ACT_DAC_LSB = 4;
    localparam int ACT_BANK = 6;
    localparam int ACT_COMPRESS = 7;
    localparam int ACT_BYPASS = 8;
    localparam int ACT_VOL_UP = 9;
    localparam int ACT_VOL_DOWN = 10;
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage : pin_function_pkg

// ---- tb/role_ref_pkg.sv ----
package role_ref_pkg;
    // control levels raised by one pin: {down, up, bypass, compress, bank, dac[1:0], adc[3:0]}
    localparam logic [10:0] ROLE_TAB [18] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h003,
        11'h00C, 11'h00F, 11'h010, 11'h020, 11'h030, 11'h040, 11'h000, 11'h000, 11'h080, 11'h100,
        11'h200, 11'h400};

    // codes above the volume-down code, and a low pin, raise nothing
    function automatic logic [10:0] act(input logic [4:0] k, input logic l);
        return (l && k < 5'h12) ? ROLE_TAB[k] : 11'h000;
    endfunction : act
endpackage : role_ref_pkg

// ---- tb/pin_function_select_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_monitor (
    input wire logic MCLK, RESET, CE, HSEL, HWRITE, HREADY,
    input wire logic [31:0] HADDR, HWDATA,
    input wire logic [1:0] HTRANS,
    input wire logic SERIAL_OUT0_PDM_PIN_IN, SERIAL_OUT0_PDM_PIN_OUT, SERIAL_OUT0_PDM_PIN_OE,
    input wire logic BIT_CLOCK_PIN_IN, BIT_CLOCK_PIN_OUT, BIT_CLOCK_PIN_OE, FRAME_CLOCK_PIN_IN,
    input wire logic DIGITAL_MIC01_PIN_IN, DIGITAL_MIC01_PIN_OE, MIC01_DATA, SERIAL_OUT0_DATA,
    input wire logic PULSE_DENSITY_OUT, BIT_CLOCK_DRIVE, BIT_CLOCK_SOURCE,
    input wire logic [3:0] MUTE_ADC,
    input wire logic [1:0] MUTE_DAC,
    input wire logic BANK_SWITCH, COMPRESS_EN, DSP_BYPASS, VOL_UP, VOL_DOWN
);
    logic live;
    logic wr;
    logic [7:0] widx;
    logic [4:0] code [4];
    logic [10:0] want;
    logic [10:0] acts;

    // shadow of the four role codes, snooped from the bus; live marks an enabled edge out of reset
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            live <= 1'b0;
            wr <= 1'b0;
            widx <= 8'h00;
            code <= '{5'h10, 5'h00, 5'h00, 5'h00};
        end else begin
            live <= CE;
            if (CE) begin
                wr <= HSEL && HREADY && HTRANS == pin_function_pkg::HTRANS_NONSEQ && HWRITE
                    && HADDR[31:10] == 22'h0 && HADDR[1:0] == 2'h0;
                widx <= HADDR[9:2];
                for (int i = 0; i < 4; i++) begin
                    if (wr && widx == 8'h39 + 8'(i)) code[i] <= HWDATA[4:0];
                end
            end
        end
    end

    // expected control levels from shadow codes and pin levels
    assign want = role_ref_pkg::act(code[0], SERIAL_OUT0_PDM_PIN_IN) | role_ref_pkg::act(code[1], BIT_CLOCK_PIN_IN)
        | role_ref_pkg::act(code[2], FRAME_CLOCK_PIN_IN) | role_ref_pkg::act(code[3], DIGITAL_MIC01_PIN_IN);
    assign acts = {VOL_DOWN, VOL_UP, DSP_BYPASS, COMPRESS_EN, BANK_SWITCH, MUTE_DAC, MUTE_ADC};

    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    AST_BYPASS:
        assert property (live |-> DSP_BYPASS == $past(want[8])) else $error("bypass level wrong");
    AST_VOLUME:
        assert property (live |-> acts[10:9] == $past(want[10:9])) else $error("volume levels wrong");
    AST_OTHER_ACTS:
        assert property (live |-> acts[7:0] == $past(want[7:0])) else $error("mute, bank or compress wrong");
    AST_SERIAL_OUT:
        assert property (live && $past(code[0]) == 5'h00 |-> SERIAL_OUT0_PDM_PIN_OE
            && SERIAL_OUT0_PDM_PIN_OUT == $past(SERIAL_OUT0_DATA)) else $error("serial data not on pin one");
    AST_PDM_OUT:
        assert property (live && $past(code[0]) == 5'h12 |-> SERIAL_OUT0_PDM_PIN_OE
            && SERIAL_OUT0_PDM_PIN_OUT == $past(PULSE_DENSITY_OUT)) else $error("pulse data not on pin one");
    AST_PIN1_INPUT:
        assert property (live && $past(code[0]) != 5'h00 && $past(code[0]) != 5'h12
            |-> !SERIAL_OUT0_PDM_PIN_OE) else $error("pin one driven in an input role");
    AST_BIT_CLOCK:
        assert property (live && $past(code[1]) == 5'h00 && $past(BIT_CLOCK_DRIVE) |-> BIT_CLOCK_PIN_OE
            && BIT_CLOCK_PIN_OUT == $past(BIT_CLOCK_SOURCE)) else $error("bit clock not driven");
    AST_MIC:
        assert property (live |-> !DIGITAL_MIC01_PIN_OE && MIC01_DATA == ($past(code[3]) == 5'h00
            && $past(DIGITAL_MIC01_PIN_IN))) else $error("mic data wrong");
endmodule : pin_function_select_monitor

bind pin_function_select pin_function_select_monitor pin_function_select_monitor_i (.*);
`default_nettype wire

// ---- tb/pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic [3:0] lvl,
    input wire logic [2:0] oe,
    input wire logic [2:0] dout,
    output logic [3:0] pin_in
);
    // buttons and clock host drive the wanted level whenever the device lets go of a pin
    assign pin_in[2:0] = (oe & dout) | (~oe & lvl[2:0]);
    // microphone pin is input only
    assign pin_in[3] = lvl[3];
endmodule : pin_partner
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic MCLK = 1'b0, RESET = 1'b1, CE = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic SERIAL_OUT0_DATA = 1'b0, PULSE_DENSITY_OUT = 1'b0, BIT_CLOCK_DRIVE = 1'b0, BIT_CLOCK_SOURCE = 1'b0;
    logic FRAME_CLOCK_DRIVE = 1'b0, FRAME_CLOCK_SOURCE = 1'b0;
    logic [3:0] lvl = 4'h0;
    wire logic HREADY, SERIAL_OUT0_PDM_PIN_IN, BIT_CLOCK_PIN_IN, FRAME_CLOCK_PIN_IN, DIGITAL_MIC01_PIN_IN;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, SERIAL_OUT0_PDM_PIN_OUT, SERIAL_OUT0_PDM_PIN_OE, BIT_CLOCK_PIN_OUT, BIT_CLOCK_PIN_OE;
    logic FRAME_CLOCK_PIN_OUT, FRAME_CLOCK_PIN_OE, DIGITAL_MIC01_PIN_OUT, DIGITAL_MIC01_PIN_OE;
    logic BIT_CLOCK_SEEN, FRAME_CLOCK_SEEN, MIC01_DATA, BANK_SWITCH, COMPRESS_EN, DSP_BYPASS, VOL_UP, VOL_DOWN;
    logic [3:0] MUTE_ADC;
    logic [1:0] MUTE_DAC;
    logic [10:0] acts;
    int fail_count, n_checks, cycles;

    // single slave: its ready is the bus ready
    assign HREADY = HREADYOUT;
    assign acts = {VOL_DOWN, VOL_UP, DSP_BYPASS, COMPRESS_EN, BANK_SWITCH, MUTE_DAC, MUTE_ADC};

    pin_function_select pin_function_select_i (.*);
    pin_partner pin_partner_i (
        .lvl(lvl),
        .oe({FRAME_CLOCK_PIN_OE, BIT_CLOCK_PIN_OE, SERIAL_OUT0_PDM_PIN_OE}),
        .dout({FRAME_CLOCK_PIN_OUT, BIT_CLOCK_PIN_OUT, SERIAL_OUT0_PDM_PIN_OUT}),
        .pin_in({DIGITAL_MIC01_PIN_IN, FRAME_CLOCK_PIN_IN, BIT_CLOCK_PIN_IN, SERIAL_OUT0_PDM_PIN_IN})
    );

    initial begin
        forever #20 MCLK = ~MCLK;
    end

    // cut a hang short
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count = fail_count + 1;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bits(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bits

    // one single word transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        HSEL <= 1'b1;
        HADDR <= a;
        HWRITE <= wr;
        HTRANS <= pin_function_pkg::HTRANS_NONSEQ;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask : bus

    // reset selections, an unmapped word, and pin one acting as volume-up button
    task automatic t_reset;
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 32'hE4 + 32'(4 * i), 32'h0, q);
            chk_word("reset selection", (i == 0) ? 32'h10 : 32'h0, q);
        end
        bus(1'b0, 32'hF4, 32'h0, q);
        chk_word("unmapped word", 32'h0, q);
        lvl <= 4'h1;
        repeat (2) @(posedge MCLK);
        chk_bits("volume up at reset", 11'h200, acts);
    endtask : t_reset

    // upper bits kept but ignored, misaligned write refused, bit clock pin as bypass
    task automatic t_regs;
        logic [31:0] q;
        bus(1'b1, 32'hE8, 32'hABCDEFEF, q);
        bus(1'b1, 32'hEA, 32'h0000001F, q);
        bus(1'b0, 32'hE8, 32'h0, q);
        chk_word("selection word", 32'h000000EF, q);
        lvl <= 4'h2;
        repeat (2) @(posedge MCLK);
        chk_bits("bypass request", 11'h100, acts);
    endtask : t_regs

    // primary roles of all four pins, both levels
    task automatic t_primary;
        logic [31:0] q;
        for (int i = 0; i < 4; i++) bus(1'b1, 32'hE4 + 32'(4 * i), 32'h0, q);
        for (int b = 0; b < 2; b++) begin
            SERIAL_OUT0_DATA <= b[0];
            PULSE_DENSITY_OUT <= !b[0];
            BIT_CLOCK_DRIVE <= 1'b1;
            BIT_CLOCK_SOURCE <= b[0];
            FRAME_CLOCK_SOURCE <= !b[0];
            lvl <= {b[0], b[0], 2'b00};
            repeat (2) @(posedge MCLK);
            chk_bits("pin one serial", 11'({1'b1, b[0]}), 11'({SERIAL_OUT0_PDM_PIN_OE, SERIAL_OUT0_PDM_PIN_OUT}));
            chk_bits("bit clock drive", 11'({1'b1, b[0]}), 11'({BIT_CLOCK_PIN_OE, BIT_CLOCK_PIN_OUT}));
            chk_bits("frame clock seen", 11'({1'b0, b[0]}), 11'({FRAME_CLOCK_PIN_OE, FRAME_CLOCK_SEEN}));
            chk_bits("mic data", 11'({1'b0, b[0]}), 11'({DIGITAL_MIC01_PIN_OE, MIC01_DATA}));
            bus(1'b1, 32'hE4, 32'h12, q);
            repeat (2) @(posedge MCLK);
            chk_bits("pin one pulse", 11'({1'b1, !b[0]}), 11'({SERIAL_OUT0_PDM_PIN_OE, SERIAL_OUT0_PDM_PIN_OUT}));
            bus(1'b1, 32'hE4, 32'h0, q);
        end
        BIT_CLOCK_DRIVE <= 1'b0;
    endtask : t_primary

    // status word, bus response, frame clock drive, bit clock seen, and freeze while disabled
    task automatic t_misc;
        logic [31:0] q;
        FRAME_CLOCK_DRIVE <= 1'b1;
        FRAME_CLOCK_SOURCE <= 1'b1;
        lvl <= 4'hA;
        repeat (2) @(posedge MCLK);
        bus(1'b0, 32'h100, 32'h0, q);
        chk_word("pin level status", 32'h0000000F, q);
        chk_word("bus response", 32'h0, 32'(HRESP));
        chk_bits("frame clock drive", 11'h003, 11'({FRAME_CLOCK_PIN_OE, FRAME_CLOCK_PIN_OUT}));
        chk_bits("mic out, bit clock seen", 11'h001, 11'({DIGITAL_MIC01_PIN_OUT, BIT_CLOCK_SEEN}));
        CE <= 1'b0;
        lvl <= 4'h0;
        repeat (2) @(posedge MCLK);
        chk_bits("frozen while disabled", 11'h003, 11'({BIT_CLOCK_SEEN, MIC01_DATA}));
        CE <= 1'b1;
        repeat (2) @(posedge MCLK);
        chk_bits("running again", 11'h000, 11'({BIT_CLOCK_SEEN, MIC01_DATA}));
        FRAME_CLOCK_DRIVE <= 1'b0;
    endtask : t_misc

    // every code on every pin, all pins high, reserved bits set
    task automatic t_roles;
        logic [31:0] q;
        lvl <= 4'hF;
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 32; c++) begin
                bus(1'b1, 32'hE4 + 32'(4 * p), 32'hE0 | 32'(c), q);
                repeat (2) @(posedge MCLK);
                chk_bits("control levels", role_ref_pkg::act(5'(c), 1'b1), acts);
            end
        end
    endtask : t_roles

    initial begin
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        t_reset();
        t_regs();
        t_primary();
        t_misc();
        t_roles();
        test_done();
    end
endmodule : tb
`default_nettype wire
